// ### fpc_params.svh
// Constants for the flash protection control block
// Functional notes
// [RULE1] Readout protection and write/erase protection are two independent mechanisms, each usable alone.
// [RULE2] Readout protection blocks external readout of memory and blocks writes to program memory and data EEPROM.
// [RULE3] On flash parts, clearing the readout-protect option automatically erases program memory and data EEPROM.
// [RULE4] On flash parts, readout protection is set and cleared through the readout-protect bit of the option byte.
// [RULE5] On mask-programmed parts, readout protection is fixed at manufacture by a mask option.
// [RULE6] While write/erase protection is active, every overwrite and erase of program memory is refused.
// [RULE7] Write/erase protection leaves data EEPROM writes allowed.
// [RULE8] Once write/erase protection is set it can never be cleared and the flash no longer accepts reprogramming; reset here clears it (opt_r to 00h).
// [RULE9] Write/erase protection is turned on through the write-protect bit of the option byte.
// [RULE10] The flash control/status register at 002Fh resets to 00h, bits 7..3 read zero, bits 2..0 are option-select, latch and program.
// [RULE11] Access to the control register needs key 56h then key AEh, in that order.
// [RULE12] An external programming tool sends the two keys itself without user intervention.
// [RULE13] Only programming methods use the control register, which governs flash program and erase.
// [RULE14] Writes to the control bits are ignored until both keys were written in order since reset.
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_CSR_ADDR 16'h002F
`define FPC_CSR_RESET 8'h00
`define FPC_KEY1 8'h56
`define FPC_KEY2 8'hAE
`define FPC_BIT_PGM 0
`define FPC_BIT_LAT 1
`define FPC_BIT_OPT 2
`define FPC_OPT_BIT_RDP 0
`define FPC_OPT_BIT_WRP 1

`endif

// ### fpc_pkg.sv
// Types for the flash protection control block
package fpc_pkg;

    typedef enum logic [2:0] {
        FPC_LOCKED = 3'b001,
        FPC_KEY1_OK = 3'b010,
        FPC_OPEN = 3'b100
    } fpc_key_e;

    typedef struct packed {
        logic opt_sel;
        logic latch;
        logic prog_en;
    } fpc_ctrl_s;

    typedef struct packed {
        logic rd_block;
        logic flash_wr_block;
        logic eep_wr_block;
    } fpc_guard_s;

endpackage

// ### fpc_key_seq.sv
// Two-key unlock sequencer for the flash control register
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_key_seq (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic [7:0] data_in,
    output logic unlocked_out
);
    fpc_pkg::fpc_key_e state_r;
    fpc_pkg::fpc_key_e state_nxt;

    // Any wrong value before unlock restarts the sequence, except a repeated 56h after the first key, which keeps the first key
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fpc_pkg::FPC_LOCKED: begin
                if (wr_in && data_in == `FPC_KEY1) begin // RULE11
                    state_nxt = fpc_pkg::FPC_KEY1_OK;
                end
            end
            fpc_pkg::FPC_KEY1_OK: begin
                if (wr_in) begin
                    if (data_in == `FPC_KEY2) begin // RULE11
                        state_nxt = fpc_pkg::FPC_OPEN;
                    end else if (data_in != `FPC_KEY1) begin
                        state_nxt = fpc_pkg::FPC_LOCKED;
                    end
                end
            end
            fpc_pkg::FPC_OPEN: state_nxt = fpc_pkg::FPC_OPEN;
            default: state_nxt = fpc_pkg::FPC_LOCKED;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= fpc_pkg::FPC_LOCKED;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    assign unlocked_out = (state_r == fpc_pkg::FPC_OPEN); // RULE14
endmodule

// ### fpc_guard.sv
// Combinational access guard from the protection states
`timescale 1ns/1ps
module fpc_guard (
    input wire logic rdp_in,
    input wire logic wrp_in,
    output fpc_pkg::fpc_guard_s guard_out
);
    always_comb begin
        guard_out.rd_block = rdp_in; // RULE2
        guard_out.flash_wr_block = rdp_in | wrp_in; // RULE2 RULE6
        guard_out.eep_wr_block = rdp_in; // RULE7
    end
endmodule

// ### fpc_top.sv
// Flash protection control top: control register, option byte, access gating
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_top #(
    parameter bit MASK_PART = 1'b0,
    parameter bit MASK_RDP = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] opt_byte_in,
    input wire logic opt_load_in,
    input wire logic opt_wr_in,
    input wire logic [7:0] opt_wdata_in,
    input wire logic ext_rd_req_in,
    input wire logic flash_wr_req_in,
    input wire logic flash_erase_req_in,
    input wire logic eep_wr_req_in,
    output logic [7:0] rdata_out,
    output logic [7:0] opt_byte_out,
    output logic ctrl_unlocked_out,
    output logic rdp_active_out,
    output logic wrp_active_out,
    output logic ext_rd_grant_out,
    output logic flash_wr_grant_out,
    output logic flash_erase_grant_out,
    output logic eep_wr_grant_out,
    output logic mass_erase_out,
    output logic opt_select_out,
    output logic latch_out,
    output logic program_out
);
    ////////////////////////////////////////////////////////////////////////
    fpc_pkg::fpc_ctrl_s ctrl_r;
    fpc_pkg::fpc_ctrl_s ctrl_nxt;
    logic [7:0] opt_r;
    logic [7:0] opt_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    fpc_pkg::fpc_guard_s grant_r;
    fpc_pkg::fpc_guard_s grant_nxt;
    logic erase_r;
    logic erase_nxt;
    logic unlocked;
    logic csr_hit;
    logic rdp;
    logic wrp;
    fpc_pkg::fpc_guard_s guard;

    function automatic logic [7:0] csr_image(input fpc_pkg::fpc_ctrl_s c);
        csr_image = {5'h00, c.opt_sel, c.latch, c.prog_en}; // RULE10
    endfunction

    assign csr_hit = (addr_in == `FPC_CSR_ADDR);

    fpc_key_seq u_keys (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .wr_in(wr_in && csr_hit && !unlocked),
        .data_in(wdata_in),
        .unlocked_out(unlocked)
    );

    // Mask parts hold readout protection fixed
    assign rdp = MASK_PART ? MASK_RDP : opt_r[`FPC_OPT_BIT_RDP]; // RULE4 RULE5 RULE1
    assign wrp = opt_r[`FPC_OPT_BIT_WRP]; // RULE9 RULE1

    fpc_guard u_guard (
        .rdp_in(rdp),
        .wrp_in(wrp),
        .guard_out(guard)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_in && csr_hit && unlocked) begin // RULE14
            ctrl_nxt.prog_en = wdata_in[`FPC_BIT_PGM];
            ctrl_nxt.latch = wdata_in[`FPC_BIT_LAT];
            ctrl_nxt.opt_sel = wdata_in[`FPC_BIT_OPT];
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_in && csr_hit) begin
            rdata_nxt = csr_image(ctrl_r); // RULE10
        end else if (rd_in) begin
            rdata_nxt = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Option byte: write protection is sticky once set
    always_comb begin
        opt_nxt = opt_r;
        erase_nxt = 1'b0;
        if (opt_load_in) begin
            opt_nxt = opt_byte_in;
            opt_nxt[`FPC_OPT_BIT_WRP] = opt_byte_in[`FPC_OPT_BIT_WRP] | wrp; // RULE8
        end else if (opt_wr_in && unlocked && ctrl_r.opt_sel && !wrp) begin // RULE8
            opt_nxt = opt_wdata_in;
            if (!MASK_PART && rdp && !opt_wdata_in[`FPC_OPT_BIT_RDP]) begin
                erase_nxt = 1'b1; // RULE3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access grants
    always_comb begin
        grant_nxt.rd_block = ext_rd_req_in && !guard.rd_block; // RULE2
        grant_nxt.flash_wr_block = flash_wr_req_in && !guard.flash_wr_block; // RULE6
        grant_nxt.eep_wr_block = eep_wr_req_in && !guard.eep_wr_block; // RULE7
    end

    logic erase_grant_r;
    logic erase_grant_nxt;
    assign erase_grant_nxt = flash_erase_req_in && !guard.flash_wr_block; // RULE6

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= '0;
            opt_r <= 8'h00;
            rdata_r <= `FPC_CSR_RESET;
            grant_r <= '0;
            erase_r <= 1'b0;
            erase_grant_r <= 1'b0;
            opt_byte_out <= 8'h00;
            ctrl_unlocked_out <= 1'b0;
            rdp_active_out <= 1'b0;
            wrp_active_out <= 1'b0;
        end else if (ce_in) begin
            ctrl_r <= ctrl_nxt;
            opt_r <= opt_nxt;
            rdata_r <= rdata_nxt;
            grant_r <= grant_nxt;
            erase_r <= erase_nxt;
            erase_grant_r <= erase_grant_nxt;
            opt_byte_out <= opt_nxt;
            ctrl_unlocked_out <= unlocked;
            rdp_active_out <= rdp;
            wrp_active_out <= wrp;
        end
    end

    always_comb begin
        rdata_out = rdata_r;
        ext_rd_grant_out = grant_r.rd_block;
        flash_wr_grant_out = grant_r.flash_wr_block;
        flash_erase_grant_out = erase_grant_r;
        eep_wr_grant_out = grant_r.eep_wr_block;
        mass_erase_out = erase_r;
        opt_select_out = ctrl_r.opt_sel;
        latch_out = ctrl_r.latch;
        program_out = ctrl_r.prog_en;
    end
endmodule

// ### fpc_chk.sv
// Assertion checker for the flash protection control block
`timescale 1ns/1ps
module fpc_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] rdata_out,
    input wire logic ctrl_unlocked_out,
    input wire logic rdp_active_out,
    input wire logic wrp_active_out,
    input wire logic ext_rd_grant_out,
    input wire logic flash_wr_grant_out,
    input wire logic flash_erase_grant_out,
    input wire logic eep_wr_grant_out,
    input wire logic mass_erase_out,
    input wire logic opt_select_out,
    input wire logic latch_out,
    input wire logic program_out
);
    wire [3:0] grants = {ext_rd_grant_out, flash_wr_grant_out,
        flash_erase_grant_out, eep_wr_grant_out};
    wire [2:0] ctrl = {opt_select_out, latch_out, program_out};
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    rdp_guard_a: assert property ($past(rdp_active_out) |-> grants == 4'h0)
        else $error("grant under readout protection");
    wrp_guard_a: assert property ($past(wrp_active_out) |-> grants[2:1] == 2'h0)
        else $error("program memory change under write protection");
    wrp_sticky_a: assert property (wrp_active_out |=> wrp_active_out)
        else $error("write protection cleared");
    rsvd_zero_a: assert property (rdata_out[7:3] == 5'h00)
        else $error("reserved read bits not zero");
    ctrl_lock_a: assert property (!ctrl_unlocked_out |-> ctrl == 3'h0)
        else $error("control bits set while locked");
    unlock_hold_a: assert property (ctrl_unlocked_out |=> ctrl_unlocked_out)
        else $error("unlock lost before reset");
    erase_pulse_a: assert property (mass_erase_out |=> !mass_erase_out)
        else $error("mass erase longer than one cycle");
    erase_cause_a: assert property (mass_erase_out |->
        $past(rdp_active_out) || $past(rdp_active_out, 2)) else $error("erase without protection");
    cover property ($rose(ctrl_unlocked_out));
    cover property (mass_erase_out);
    cover property (wrp_active_out && grants[0]);
endmodule

// ### fpc_prog.sv
// Programming tool model driving the register bus
`timescale 1ns/1ps
module fpc_prog (
    input wire logic clk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] addr_out,
    output logic [7:0] data_out
);
    initial begin
        {wr_out, rd_out, addr_out, data_out} = 26'h0;
    end
    // One cycle per access; released data lines show the inverse value
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {wr_out, rd_out, addr_out, data_out} <= {w, !w, a, d};
        @(posedge clk_in);
        {wr_out, rd_out, data_out} <= {2'h0, ~d};
    endtask
    task automatic unlock();
        access(1'h1, 16'h002F, 8'h56);
        access(1'h1, 16'h002F, 8'hAE);
    endtask
endmodule

// ### tb_flash_protection_control.sv
// Self-checking testbench for the flash protection control block
`timescale 1ns/1ps
module tb_flash_protection_control;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic wr_in, rd_in, ctrl_unlocked_out, rdp_active_out, wrp_active_out, mass_erase_out;
    logic ext_rd_grant_out, flash_wr_grant_out, flash_erase_grant_out, eep_wr_grant_out;
    logic opt_select_out, latch_out, program_out, opt_load_in, opt_wr_in;
    logic ext_rd_req_in, flash_wr_req_in, flash_erase_req_in, eep_wr_req_in;
    logic [15:0] addr_in;
    logic [7:0] wdata_in, rdata_out, opt_byte_out, opt_byte_in, opt_wdata_in;
    int n_errors = 0;
    int cmp_count = 0;
    wire [3:0] grants = {ext_rd_grant_out, flash_wr_grant_out,
        flash_erase_grant_out, eep_wr_grant_out};
    initial begin
        {opt_load_in, opt_wr_in, opt_byte_in, opt_wdata_in} = 18'h0;
        {ext_rd_req_in, flash_wr_req_in, flash_erase_req_in, eep_wr_req_in} = 4'h0;
    end
    always #50 clk_in = ~clk_in;
    fpc_prog prog_i (.clk_in, .wr_out(wr_in), .rd_out(rd_in), .addr_out(addr_in),
        .data_out(wdata_in));
    fpc_top fpc_top_i (.clk_in, .rst_in, .ce_in(1'h1), .addr_in, .wr_in, .rd_in, .wdata_in,
        .opt_byte_in, .opt_load_in, .opt_wr_in, .opt_wdata_in, .ext_rd_req_in, .flash_wr_req_in,
        .flash_erase_req_in, .eep_wr_req_in, .rdata_out, .opt_byte_out, .ctrl_unlocked_out,
        .rdp_active_out, .wrp_active_out, .ext_rd_grant_out, .flash_wr_grant_out,
        .flash_erase_grant_out, .eep_wr_grant_out, .mass_erase_out, .opt_select_out,
        .latch_out, .program_out);
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] d);
        prog_i.access(1'h1, 16'h002F, d);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        prog_i.access(1'h0, a, 8'h00);
        @(negedge clk_in);
        cmp("read data", exp, rdata_out);
    endtask
    // All requests up for one cycle, grants seen one cycle later
    task automatic req_chk(input logic [3:0] exp);
        @(posedge clk_in);
        {ext_rd_req_in, flash_wr_req_in, flash_erase_req_in, eep_wr_req_in} <= 4'hF;
        @(posedge clk_in);
        {ext_rd_req_in, flash_wr_req_in, flash_erase_req_in, eep_wr_req_in} <= 4'h0;
        @(negedge clk_in);
        cmp("grants", {4'h0, exp}, {4'h0, grants});
    endtask
    // Load or program the option byte; expect {erase seen, write prot, read prot}
    task automatic opt_op(input logic ld, input logic [7:0] v, input logic [7:0] exp);
        logic seen;
        seen = 1'h0;
        @(posedge clk_in);
        {opt_byte_in, opt_wdata_in, opt_load_in, opt_wr_in} <= {v, v, ld, !ld};
        @(posedge clk_in);
        {opt_load_in, opt_wr_in} <= 2'h0;
        repeat (3) begin
            @(negedge clk_in);
            seen = seen | mass_erase_out;
        end
        cmp("protect", exp, {5'h00, seen, wrp_active_out, rdp_active_out});
        cmp("option byte", exp & 8'h03, opt_byte_out);
    endtask
    task automatic t_keys();
        rd_chk(16'h002F, 8'h00);
        wr_reg(8'h07);
        wr_reg(8'h56);
        wr_reg(8'h12);
        wr_reg(8'hAE);
        wr_reg(8'h07);
        rd_chk(16'h002F, 8'h00);
        prog_i.unlock();
        wr_reg(8'hFF);
        rd_chk(16'h002F, 8'h07);
        rd_chk(16'h0030, 8'h00);
    endtask
    task automatic t_prot();
        req_chk(4'hF);
        opt_op(1'h1, 8'h01, 8'h01);
        req_chk(4'h0);
        wr_reg(8'h04);
        opt_op(1'h0, 8'h00, 8'h04);
        opt_op(1'h0, 8'h02, 8'h02);
        req_chk(4'h9);
        opt_op(1'h0, 8'h00, 8'h02);
        opt_op(1'h1, 8'h00, 8'h02);
        req_chk(4'h9);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'h0;
        t_keys();
        t_prot();
        results();
    end
endmodule
bind fpc_top fpc_chk fpc_chk_i (.clk_in, .rst_in, .rdata_out, .ctrl_unlocked_out,
    .rdp_active_out, .wrp_active_out, .ext_rd_grant_out, .flash_wr_grant_out,
    .flash_erase_grant_out, .eep_wr_grant_out, .mass_erase_out, .opt_select_out,
    .latch_out, .program_out);
